// ==== rtl/dss_setup_decoder.sv ====
// Purpose: Decodes setup selectors and stored parameters into drive settings.
// Assumes: Selector pins are asynchronous; store levels are stable at power-up.
// Notes: Settings are captured once after debounce and held until reset.
`timescale 1ns/1ps
module dss_setup_decoder
    import dss_pkg::*;
#(
    parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
)
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               arst_n,
    // Setup selector pins, closed reads as one
    input  wire logic [DIP_W-1:0]   dip_selector,
    input  wire logic [ROT_W-1:0]   rotary_selector,
    // Non-volatile store
    input  wire dss_store_s         store,
    input  wire logic [DIV_W-1:0]   aux_position_divider,
    // Auxiliary interpolator
    input  wire logic [15:0]        aux_cycle_count,
    input  wire logic [FRAC_W-1:0]  aux_cycle_fraction,
    // Decoded settings
    output dss_setting_s            setting,
    output logic                    line_count_illegal,
    output logic [POS_W-1:0]        aux_position
);
    logic [DIP_W-1:0] dip_meta;
    logic [DIP_W-1:0] dip_sync;
    logic [ROT_W-1:0] rot_meta;
    logic [ROT_W-1:0] rot_sync;
    logic [DIP_W-1:0] dip_prev;
    logic [ROT_W-1:0] rot_prev;
    logic [CNT_W-1:0] stable_cnt;
    dss_state_e       state;
    dss_state_e       next_state;
    logic [POS_W-1:0] aux_scaled;

    // Two-stage synchronisers for the selector pins.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dip_meta <= '0;
            dip_sync <= '0;
            rot_meta <= '0;
            rot_sync <= '0;
        end else begin
            dip_meta <= dip_selector;
            dip_sync <= dip_meta;
            rot_meta <= rotary_selector;
            rot_sync <= rot_meta;
        end
    end

    wire logic moved   = (dip_sync != dip_prev) || (rot_sync != rot_prev);
    wire logic settled = (stable_cnt == CNT_W'(DEBOUNCE_LEN - 1));

    // Positions 3 and 4 of the DIP are read but never steer a setting.
    wire logic dip_closed1 = dip_sync[0];
    wire logic dip_closed2 = dip_sync[1];

    wire logic torque_sel =
        (store.control_loop_select == DSS_LOOP_FOLLOW) ? dip_closed1 :
        (store.control_loop_select == DSS_LOOP_TORQUE);
    wire logic smart_sel =
        (store.feedback_kind_select == DSS_FB_FOLLOW) ? dip_closed2 :
        (store.feedback_kind_select == DSS_FB_SMART);

    wire logic        rot_valid   = (rot_sync <= ROT_MAX);
    wire logic        stored_ok   = dss_line_legal(store.stored_line_count);
    wire logic [15:0] stored_used = stored_ok ? store.stored_line_count : LINES_DEFAULT;
    wire logic [15:0] lines_sel   =
        (rot_sync == '0) ? stored_used : dss_rotary_lines(rot_sync);

    wire logic emul_en =
        (smart_sel && !store.feedback_origin_select) ||
        (store.feedback_origin_select && store.option_hires_sensor);

    wire logic aux_run =
        (store.aux_sensor_kind == DSS_AUX_INCR_HALL) ||
        (store.aux_sensor_kind == DSS_AUX_SC_HALL) ||
        (store.aux_sensor_kind == DSS_AUX_ABSOLUTE);

    always_comb begin
        next_state = state;
        case (state)
            DSS_ST_SETTLE: if (settled) next_state = DSS_ST_LATCH;
            DSS_ST_LATCH:  next_state = DSS_ST_HOLD;
            DSS_ST_HOLD:   next_state = DSS_ST_HOLD;
            default:       next_state = DSS_ST_SETTLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state      <= DSS_ST_SETTLE;
            dip_prev   <= '0;
            rot_prev   <= '0;
            stable_cnt <= '0;
        end else begin
            state    <= next_state;
            dip_prev <= dip_sync;
            rot_prev <= rot_sync;
            if (moved || state != DSS_ST_SETTLE) begin
                stable_cnt <= '0;
            end else if (!settled) begin
                stable_cnt <= stable_cnt + CNT_W'(1);
            end
        end
    end

    // Capture once; the hold state never revisits the selectors.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            setting            <= '0;
            line_count_illegal <= 1'b0;
        end else if (state == DSS_ST_LATCH) begin
            setting.torque_mode           <= torque_sel;
            setting.smart_feedback_sensor <= smart_sel;
            setting.line_count            <= smart_sel ? lines_sel : '0;
            setting.current_gain_index    <= smart_sel ? '0 : rot_sync;
            setting.emulated_out_enable   <= emul_en;
            setting.aux_may_commutate     <= aux_run;
            setting.settings_valid        <= rot_valid;
            line_count_illegal            <= smart_sel && (rot_sync == '0) && !stored_ok;
        end
    end

    dss_aux_scaler u_scaler (
        .clock                (clock),
        .arst_n               (arst_n),
        .cycle_count          (aux_cycle_count),
        .cycle_fraction       (aux_cycle_fraction),
        .aux_position_divider (aux_position_divider),
        .position_count       (aux_scaled)
    );

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            aux_position <= '0;
        end else begin
            aux_position <= aux_scaled;
        end
    end
endmodule

// ==== rtl/dss_pkg.sv ====
// Purpose: Shared constants and types for the drive setup selector decoder.
// Assumes: One 125 MHz clock and an asynchronous active-low reset.
// Notes: Stored parameters come from the non-volatile store as plain levels.
package dss_pkg;

    localparam int          CLOCK_MHZ        = 125;
    localparam int          DEBOUNCE_US      = 10000;
    localparam int          DEBOUNCE_CYCLES  = DEBOUNCE_US * CLOCK_MHZ;
    localparam int          CNT_W            = 21;
    localparam logic [15:0] LINES_DEFAULT    = 16'h01F4;
    localparam int          DIP_W            = 4;
    localparam int          ROT_W            = 4;
    localparam int          FRAC_W           = 16;
    localparam int          POS_W            = 32;
    localparam int          DIV_W            = 16;
    localparam logic [3:0]  ROT_MAX          = 4'h9;

    typedef enum logic [1:0] {
        DSS_LOOP_TORQUE   = 2'h0,
        DSS_LOOP_VELOCITY = 2'h1,
        DSS_LOOP_FOLLOW   = 2'h2
    } dss_loop_e;

    typedef enum logic [1:0] {
        DSS_FB_SMART  = 2'h0,
        DSS_FB_SIXSTEP = 2'h1,
        DSS_FB_FOLLOW = 2'h2
    } dss_fb_e;

    typedef enum logic [2:0] {
        DSS_AUX_INCR      = 3'h0,
        DSS_AUX_INCR_HALL = 3'h1,
        DSS_AUX_SINCOS    = 3'h2,
        DSS_AUX_SC_HALL   = 3'h3,
        DSS_AUX_ABSOLUTE  = 3'h4
    } dss_aux_e;

    typedef enum logic [2:0] {
        DSS_ST_SETTLE = 3'b001,
        DSS_ST_LATCH  = 3'b010,
        DSS_ST_HOLD   = 3'b100
    } dss_state_e;

    typedef struct packed {
        dss_loop_e   control_loop_select;
        dss_fb_e     feedback_kind_select;
        logic [15:0] stored_line_count;
        logic        feedback_origin_select;
        logic        option_hires_sensor;
        dss_aux_e    aux_sensor_kind;
    } dss_store_s;

    typedef struct packed {
        logic        torque_mode;
        logic        smart_feedback_sensor;
        logic [15:0] line_count;
        logic [3:0]  current_gain_index;
        logic        emulated_out_enable;
        logic        aux_may_commutate;
        logic        settings_valid;
    } dss_setting_s;

    function automatic logic [15:0] dss_rotary_lines(input logic [3:0] pos);
        logic [15:0] v;
        v = 16'h0000;
        case (pos)
            4'h1: v = 16'h0200;
            4'h2: v = 16'h03E8;
            4'h3: v = 16'h0400;
            4'h4: v = 16'h07D0;
            4'h5: v = 16'h0800;
            4'h6: v = 16'h1000;
            4'h7: v = 16'h1388;
            4'h8: v = 16'h2000;
            4'h9: v = 16'h2710;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    function automatic logic dss_line_legal(input logic [15:0] n);
        logic ok;
        ok = 1'b0;
        case (n)
            16'h0080, 16'h0200, 16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h4000,
            16'h8000, 16'h007D, 16'h01F4, 16'h03E8, 16'h07D0, 16'h09C4, 16'h1388,
            16'h2710, 16'h4E20: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

endpackage

// ==== rtl/dss_aux_scaler.sv ====
// Purpose: Builds the auxiliary sin-cos position count from cycles and fraction.
// Assumes: The divisor is held steady by the user; zero is treated as one.
// Notes: A sequential restoring divider, one quotient bit per clock.
`timescale 1ns/1ps
module dss_aux_scaler
    import dss_pkg::*;
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               arst_n,
    // Interpolated input
    input  wire logic [15:0]        cycle_count,
    input  wire logic [FRAC_W-1:0]  cycle_fraction,
    input  wire logic [DIV_W-1:0]   aux_position_divider,
    // Scaled result
    output logic [POS_W-1:0]        position_count
);
    localparam logic [5:0] BITS = 6'h20;

    wire logic [POS_W-1:0] raw_position = {cycle_count, cycle_fraction};
    wire logic [DIV_W-1:0] divisor      = (aux_position_divider == '0) ? 16'h0001
                                                                      : aux_position_divider;

    logic [POS_W-1:0] dividend;
    logic [POS_W-1:0] quotient;
    logic [DIV_W:0]   remainder;
    logic [5:0]       bit_cnt;

    wire logic [DIV_W:0] trial    = {remainder[DIV_W-1:0], dividend[POS_W-1]};
    wire logic           fits     = trial >= {1'b0, divisor};
    wire logic [DIV_W:0] next_rem = fits ? trial - {1'b0, divisor} : trial;
    wire logic           done     = (bit_cnt == BITS);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dividend       <= '0;
            quotient       <= '0;
            remainder      <= '0;
            bit_cnt        <= '0;
            position_count <= '0;
        end else if (done) begin
            position_count <= quotient;
            dividend       <= raw_position;
            quotient       <= '0;
            remainder      <= '0;
            bit_cnt        <= '0;
        end else begin
            dividend  <= {dividend[POS_W-2:0], 1'b0};
            quotient  <= {quotient[POS_W-2:0], fits};
            remainder <= next_rem;
            bit_cnt   <= bit_cnt + 6'h01;
        end
    end
endmodule

// ==== bench/dss_setup_model.sv ====
// Purpose: Setup switch model feeding the decoder's selector pins.
// Assumes: Closed contacts read as one.
// Notes: While bounce is high the rotary contact chatters every clock.
`timescale 1ns/1ps
module dss_setup_model
    import dss_pkg::*;
(
    // Clock
    input  wire logic       clock,
    // Commanded positions
    input  wire logic       bounce,
    input  wire logic [3:0] dip_set,
    input  wire logic [3:0] rot_set,
    // Selector pins
    output logic [3:0]      dip_selector,
    output logic [3:0]      rotary_selector
);
    logic chatter;
    always_ff @(posedge clock) begin
        chatter <= bounce & ~chatter;
    end
    assign dip_selector    = dip_set;
    assign rotary_selector = rot_set ^ {3'h0, chatter};
endmodule

// ==== bench/dss_setup_decoder_props.sv ====
// Purpose: Port checks for the setup decoder.
// Assumes: Settings load on the edge that raises the valid flag.
// Notes: Store levels stay put while settings are held.
`timescale 1ns/1ps
module dss_setup_decoder_props
    import dss_pkg::*;
#(
    parameter int DEBOUNCE_LEN = 8
)
(
    // Clock and reset
    input wire logic              clock,
    input wire logic              arst_n,
    // Selectors and store
    input wire logic [DIP_W-1:0]  dip_selector,
    input wire logic [ROT_W-1:0]  rotary_selector,
    input wire dss_store_s        store,
    input wire logic [DIV_W-1:0]  aux_position_divider,
    input wire logic [15:0]       aux_cycle_count,
    input wire logic [FRAC_W-1:0] aux_cycle_fraction,
    // Results
    input wire dss_setting_s      setting,
    input wire logic              line_count_illegal,
    input wire logic [POS_W-1:0]  aux_position
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    dss_setting_s q;
    dss_store_s   t;
    logic         v;
    assign q = setting;
    assign t = store;
    assign v = setting.settings_valid;
    property p_hold; v |=> $stable(q); endproperty
    a_hold: assert property (p_hold) else $error("settings moved");
    property p_wait; $rose(arst_n) |-> !v [*8]; endproperty
    a_wait: assert property (p_wait) else $error("valid too early");
    // Pins reach the capture edge through two stages, so they are compared three cycles back.
    property p_ldip; $rose(v) && t.control_loop_select == DSS_LOOP_FOLLOW
        |-> q.torque_mode == $past(dip_selector[0], 3); endproperty
    a_ldip: assert property (p_ldip) else $error("loop from dip");
    property p_lpar; $rose(v) && t.control_loop_select != DSS_LOOP_FOLLOW
        |-> q.torque_mode == (t.control_loop_select == DSS_LOOP_TORQUE); endproperty
    a_lpar: assert property (p_lpar) else $error("loop from store");
    property p_fdip; $rose(v) && t.feedback_kind_select == DSS_FB_FOLLOW
        |-> q.smart_feedback_sensor == $past(dip_selector[1], 3); endproperty
    a_fdip: assert property (p_fdip) else $error("feedback from dip");
    property p_fpar; $rose(v) && t.feedback_kind_select != DSS_FB_FOLLOW
        |-> q.smart_feedback_sensor == (t.feedback_kind_select == DSS_FB_SMART); endproperty
    a_fpar: assert property (p_fpar) else $error("feedback from store");
    property p_mode; v |-> (q.smart_feedback_sensor ? q.current_gain_index == 4'h0
        : q.line_count == 16'h0000); endproperty
    a_mode: assert property (p_mode) else $error("rotary meaning");
    property p_rot9; $rose(v) && q.smart_feedback_sensor && $past(rotary_selector, 3) == 4'h9
        |-> q.line_count == 16'h2710; endproperty
    a_rot9: assert property (p_rot9) else $error("rotary nine");
    property p_dflt; v && line_count_illegal |-> q.line_count == 16'h01F4; endproperty
    a_dflt: assert property (p_dflt) else $error("default count");
    property p_emu; $rose(v) |-> q.emulated_out_enable == (t.feedback_origin_select
        ? t.option_hires_sensor : q.smart_feedback_sensor); endproperty
    a_emu: assert property (p_emu) else $error("emulated output");
    property p_aux; $rose(v) |-> q.aux_may_commutate == (t.aux_sensor_kind inside
        {DSS_AUX_INCR_HALL, DSS_AUX_SC_HALL, DSS_AUX_ABSOLUTE}); endproperty
    a_aux: assert property (p_aux) else $error("aux commutation");
    c_valid: cover property ($rose(v));
    c_illegal: cover property (v && line_count_illegal);
    c_six: cover property (v && !q.smart_feedback_sensor);
endmodule
bind dss_setup_decoder dss_setup_decoder_props #(.DEBOUNCE_LEN(DEBOUNCE_LEN)) u_props (
    .clock(clock), .arst_n(arst_n), .dip_selector(dip_selector),
    .rotary_selector(rotary_selector), .store(store),
    .aux_position_divider(aux_position_divider), .aux_cycle_count(aux_cycle_count),
    .aux_cycle_fraction(aux_cycle_fraction), .setting(setting),
    .line_count_illegal(line_count_illegal), .aux_position(aux_position));

// ==== bench/drive_setup_switch_decoder_test.sv ====
// Purpose: Self-checking bench for the setup decoder.
// Assumes: Debounce shortened to 8 cycles.
// Notes: Every scenario resets the decoder afresh.
`timescale 1ns/1ps
module drive_setup_switch_decoder_test
    import dss_pkg::*;
;
    logic         clock = 1'b0;
    logic         arst_n = 1'b0;
    logic         bounce = 1'b0;
    logic [3:0]   dip_set = 4'hC;
    logic [3:0]   rot_set = 4'h0;
    logic [3:0]   dip_selector;
    logic [3:0]   rotary_selector;
    dss_store_s   store = '0;
    logic [15:0]  div = 16'h0001;
    logic [15:0]  acnt = 16'h0000;
    logic [15:0]  afrac = 16'h0000;
    dss_setting_s setting;
    logic         illegal;
    logic [31:0]  aux_position;
    int           miscompares = 0;
    int           n_tests = 0;
    always #4 clock = ~clock;
    dss_setup_model dss_setup_model_i (.clock(clock), .bounce(bounce), .dip_set(dip_set),
        .rot_set(rot_set), .dip_selector(dip_selector), .rotary_selector(rotary_selector));
    dss_setup_decoder #(.DEBOUNCE_LEN(8)) dss_setup_decoder_i (.clock(clock), .arst_n(arst_n),
        .dip_selector(dip_selector), .rotary_selector(rotary_selector), .store(store),
        .aux_position_divider(div), .aux_cycle_count(acnt), .aux_cycle_fraction(afrac),
        .setting(setting), .line_count_illegal(illegal), .aux_position(aux_position));
    task automatic report_and_stop;
        if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_set(input dss_setting_s exp);
        cmp_vec("setting", 32'(exp), 32'(setting));
    endtask
    function automatic dss_setting_s mk(logic a, logic b, logic [15:0] n, logic [3:0] g,
        logic e, logic c);
        return {a, b, n, g, e, c, 1'b1};
    endfunction
    function automatic dss_store_s st(dss_loop_e l, dss_fb_e f, logic [15:0] n, logic o,
        logic h, dss_aux_e k);
        return {l, f, n, o, h, k};
    endfunction
    task automatic start(input logic [3:0] d, input logic [3:0] r, input dss_store_s s);
        @(negedge clock);
        arst_n = 1'b0;
        dip_set = d;
        rot_set = r;
        store = s;
        repeat (10) @(negedge clock);
        arst_n = 1'b1;
    endtask
    task automatic wait_valid;
        for (int i = 0; i < 40; i++) begin
            if (setting.settings_valid === 1'b1) return;
            @(negedge clock);
        end
        miscompares++;
        report_and_stop();
    endtask
    task automatic t_follow;
        div = 16'h0002;
        acnt = 16'h0003;
        afrac = 16'h8000;
        start(4'hF, 4'h5, st(DSS_LOOP_FOLLOW, DSS_FB_FOLLOW, 16'h01F4, 1'b0, 1'b0, DSS_AUX_INCR));
        wait_valid();
        cmp_set(mk(1'b1, 1'b1, 16'h0800, 4'h0, 1'b1, 1'b0));
        dip_set = 4'h0;
        rot_set = 4'h2;
        repeat (80) @(negedge clock);
        cmp_set(mk(1'b1, 1'b1, 16'h0800, 4'h0, 1'b1, 1'b0));
        cmp_vec("aux_position", 32'h0001C000, aux_position);
    endtask
    task automatic t_sixstep;
        div = 16'h0000;
        acnt = 16'h0001;
        afrac = 16'h0000;
        start(4'h0, 4'h3, st(DSS_LOOP_FOLLOW, DSS_FB_FOLLOW, 16'h01F4, 1'b0, 1'b0,
            DSS_AUX_INCR_HALL));
        wait_valid();
        cmp_set(mk(1'b0, 1'b0, 16'h0000, 4'h3, 1'b0, 1'b1));
        repeat (80) @(negedge clock);
        cmp_vec("aux_position", 32'h00010000, aux_position);
    endtask
    task automatic t_store(input logic [3:0] d, input logic [3:0] r, input dss_store_s s,
        input dss_setting_s e, input logic bad);
        start(d, r, s);
        wait_valid();
        cmp_set(e);
        cmp_vec("line_count_illegal", 32'(bad), 32'(illegal));
    endtask
    task automatic t_range;
        start(4'h3, 4'hA, st(DSS_LOOP_FOLLOW, DSS_FB_FOLLOW, 16'h01F4, 1'b0, 1'b0, DSS_AUX_INCR));
        repeat (40) @(negedge clock);
        cmp_vec("settings_valid", 32'h0, 32'(setting.settings_valid));
        cmp_vec("line_count", 32'h0, 32'(setting.line_count));
        cmp_vec("smart_feedback_sensor", 32'h1, 32'(setting.smart_feedback_sensor));
    endtask
    task automatic t_bounce;
        bounce = 1'b1;
        start(4'h3, 4'h1, st(DSS_LOOP_FOLLOW, DSS_FB_FOLLOW, 16'h01F4, 1'b0, 1'b0, DSS_AUX_INCR));
        repeat (20) @(negedge clock);
        bounce = 1'b0;
        repeat (7) @(negedge clock);
        cmp_vec("settings_valid", 32'h0, 32'(setting.settings_valid));
        wait_valid();
        cmp_set(mk(1'b1, 1'b1, 16'h0200, 4'h0, 1'b1, 1'b0));
    endtask
    initial begin
        t_follow();
        t_sixstep();
        t_store(4'h0, 4'h0, st(DSS_LOOP_TORQUE, DSS_FB_SMART, 16'h09C4, 1'b1, 1'b1,
            DSS_AUX_ABSOLUTE), mk(1'b1, 1'b1, 16'h09C4, 4'h0, 1'b1, 1'b1), 1'b0);
        t_store(4'hF, 4'h0, st(DSS_LOOP_VELOCITY, DSS_FB_SMART, 16'h0123, 1'b1, 1'b0,
            DSS_AUX_SINCOS), mk(1'b0, 1'b1, 16'h01F4, 4'h0, 1'b0, 1'b0), 1'b1);
        t_store(4'hE, 4'h9, st(DSS_LOOP_FOLLOW, DSS_FB_FOLLOW, 16'h01F4, 1'b0, 1'b0,
            DSS_AUX_SC_HALL), mk(1'b0, 1'b1, 16'h2710, 4'h0, 1'b1, 1'b1), 1'b0);
        t_store(4'hF, 4'h7, st(DSS_LOOP_FOLLOW, DSS_FB_SIXSTEP, 16'h01F4, 1'b0, 1'b0,
            DSS_AUX_INCR), mk(1'b1, 1'b0, 16'h0000, 4'h7, 1'b0, 1'b0), 1'b0);
        t_range();
        t_bounce();
        report_and_stop();
    end
endmodule
